/* common/wie_pkg.sv */
package wie_pkg;
   // Service interval exponent limits
   localparam logic [4:0] EXP_MIN     = 5'h06;
   localparam logic [4:0] EXP_MAX     = 5'h10;
   localparam logic [4:0] EXP_DEFAULT = 5'h06;
   // Time unit of the interval: 128 us at 40 MHz
   localparam int UNIT_NS     = 128000;
   localparam int CLK_NS      = 25;
   localparam int UNIT_CYCLES = UNIT_NS / CLK_NS;
   // Periodic share of channel time, percent
   localparam int PERIODIC_PCT = 80;
   localparam int BORROW_PCT   = 20;
   // Low-power attempts per interval
   localparam logic [1:0] LP_ATTEMPTS = 2'h3;
   // Host retry budget on transmission errors
   localparam logic [2:0] RETRY_LIMIT = 3'h5;
   // Liveness timeout default, in 128 us units
   localparam logic [15:0] LIVENESS_UNITS = 16'h1000;
   // Token kinds host to device
   typedef enum logic [3:0] {
      WIE_TOK_NONE = 4'b0001,
      WIE_TOK_IN   = 4'b0010,
      WIE_TOK_OUT  = 4'b0100,
      WIE_TOK_CTRL = 4'b1000
   } wie_tok_e;
   // Handshake kinds device to host
   typedef enum logic [4:0] {
      WIE_HS_NONE  = 5'b00001,
      WIE_HS_DATA  = 5'b00010,
      WIE_HS_ACK   = 5'b00100,
      WIE_HS_NAK   = 5'b01000,
      WIE_HS_STALL = 5'b10000
   } wie_hs_e;
   // Control request codes; all but set-feature rewind the window
   localparam logic [1:0] REQ_SET_CONFIG = 2'h0;
   localparam logic [1:0] REQ_SET_IFACE  = 2'h1;
   localparam logic [1:0] REQ_CLEAR_FEAT = 2'h2;
   localparam logic [1:0] REQ_SET_FEAT   = 2'h3;
endpackage

/* common/wie_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface wie_link_if #(parameter int WIDTH = 8);
   wie_pkg::wie_tok_e tok;         // Token, one-cycle pulse when not NONE
   logic [1:0]        req;         // Control request code with CTRL token
   logic              seq;         // Window sequence bit with OUT data
   logic [WIDTH-1:0]  hdata;       // OUT payload
   logic [4:0]        exponent;    // Reported service interval exponent
   logic              low_power;   // Endpoint is a low-power IN
   logic              notify_type; // Endpoint uses ready notices
   logic              is_in;       // Endpoint direction
   wie_pkg::wie_hs_e  hs;          // Answer, one-cycle pulse
   logic [WIDTH-1:0]  ddata;       // IN payload with DATA
   logic              dseq;        // Sequence bit with DATA
   logic              ready_notice; // endpoint_ready_notice pulse
   modport device (input tok, req, seq, hdata,
                   output exponent, low_power, notify_type, is_in,
                   hs, ddata, dseq, ready_notice);
   modport host (output tok, req, seq, hdata,
                 input exponent, low_power, notify_type, is_in,
                 hs, ddata, dseq, ready_notice);
endinterface
`default_nettype wire

/* hdl/wie_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module wie_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be 2^n");
   end
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0]                 wr;
      logic [AW:0]                 rd;
   } wie_fifo_s;
   wie_fifo_s st, next_st;
   logic      push, pop;
   // Full when pointers differ only in wrap bit
   assign in_ready  = !((st.wr[AW] != st.rd[AW]) &&
                        (st.wr[AW-1:0] == st.rd[AW-1:0]));
   assign out_valid = st.wr != st.rd;
   assign out_data  = st.mem[st.rd[AW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   // Pointer and storage update
   always_comb begin
      next_st = st;
      if (push) begin
         next_st.mem[st.wr[AW-1:0]] = in_data;
         next_st.wr = st.wr + 1'b1;
      end
      if (pop) next_st.rd = st.rd + 1'b1;
   end
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
endmodule
`default_nettype wire

/* hdl/wie_device.sv */
// Notes on behaviour
// - Host keeps periodic traffic within 80 percent
// - Report service exponent limited 6 to 16
// - Interval is 2^(x-1) units of 128 us
// - Host polls anywhere inside the interval
// - Endpoint assumes no fixed poll spacing
// - Normal IN without data answers NAK
// - Low-power IN without data may stay silent
// - OUT without buffer room answers NAK
// - Control requests other than set-feature rewind the window state
// - Host rewinds window after control completes
// - Host resumes next interval after NAK
// - Periodic endpoint sends no ready notice
// - Host waits for ready notice when notifying
// - STALL or retry exhaustion halts the pipe
// - Low-power IN NAKs once per liveness timeout
// - Host gives low-power IN three attempts (host here ends the interval after one silent poll)
`timescale 1ns/1ps
`default_nettype none
module wie_device #(
   parameter int         WIDTH        = 8,
   parameter int         DEPTH        = 16,
   parameter logic [4:0] EXPONENT     = wie_pkg::EXP_DEFAULT,
   parameter bit         LOW_POWER    = 1'b0,
   parameter bit         NOTIFY_TYPE  = 1'b0,
   parameter bit         IS_IN        = 1'b1,
   parameter int         UNIT_CYCLES  = wie_pkg::UNIT_CYCLES,
   parameter logic [15:0] LIVE_UNITS  = wie_pkg::LIVENESS_UNITS
) (
   input  wire logic             ref_clk,
   input  wire logic             rst,
   wie_link_if.device            link,
   input  wire logic             user_valid,
   output logic                  user_ready,
   input  wire logic [WIDTH-1:0] user_data,
   output logic                  recv_valid,
   input  wire logic             recv_ready,
   output logic      [WIDTH-1:0] recv_data,
   input  wire logic             halt_req,
   output logic                  halted,
   input  wire logic             data_ready
);
   // Elaboration checks; the counters assume these ranges
   if (EXPONENT < wie_pkg::EXP_MIN || EXPONENT > wie_pkg::EXP_MAX) begin
      $error("EXPONENT out of range");
   end
   if (UNIT_CYCLES < 1) begin
      $error("UNIT_CYCLES must be positive");
   end
   if (WIDTH < 1) begin
      $error("WIDTH must be positive");
   end
   // Zero would defeat the low-power silence
   if (LIVE_UNITS == 16'h0000) begin
      $error("LIVE_UNITS must be nonzero");
   end
   if (DEPTH < 2) begin
      $error("DEPTH too small");
   end
   // Whole endpoint state in one record
   typedef struct packed {
      wie_pkg::wie_hs_e hs;
      logic [WIDTH-1:0] ddata;
      logic             dseq;
      logic             tx_seq;
      logic             rx_seq;
      logic             halted;
      logic             pend_data;
      logic             ready_notice;
      logic             flow_ctl;
      logic [31:0]      unit_cnt;
      logic [15:0]      live_cnt;
   } wie_dev_s;
   wie_dev_s st, next_st;
   // Direction buffer: IN takes user data, OUT gives host data
   logic             f_in_valid, f_in_ready, f_out_valid, f_out_ready;
   logic [WIDTH-1:0] f_in_data, f_out_data;
   // Token decode; control codes but set-feature rewind
   logic             in_tok, out_tok, ctrl_tok, rewind;
   assign in_tok   = link.tok == wie_pkg::WIE_TOK_IN;
   assign out_tok  = link.tok == wie_pkg::WIE_TOK_OUT;
   assign ctrl_tok = link.tok == wie_pkg::WIE_TOK_CTRL;
   assign rewind   = ctrl_tok && link.req != wie_pkg::REQ_SET_FEAT;
   // Sixteen words absorb bursts between polls
   wie_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .in_valid  (f_in_valid),
      .in_ready  (f_in_ready),
      .in_data   (f_in_data),
      .out_valid (f_out_valid),
      .out_ready (f_out_ready),
      .out_data  (f_out_data)
   );
   // Buffer joins: OUT accepted only on fresh sequence when not halted
   logic out_accept, out_fresh;
   assign out_fresh   = link.seq == st.rx_seq;
   assign out_accept  = !IS_IN && out_tok && !st.halted && f_in_ready;
   assign f_in_valid  = IS_IN ? user_valid : (out_accept && out_fresh);
   assign f_in_data   = IS_IN ? user_data : link.hdata;
   assign user_ready  = IS_IN ? f_in_ready : 1'b0;
   assign recv_valid  = IS_IN ? 1'b0 : f_out_valid;
   assign recv_data   = f_out_data;
   // IN pops on ACK of the pending word; OUT drains to the user
   logic in_ack;
   assign in_ack      = IS_IN && out_tok && st.pend_data && !st.halted;
   assign f_out_ready = IS_IN ? in_ack : recv_ready;
   // Static descriptor view
   assign link.exponent     = EXPONENT;
   assign link.low_power    = LOW_POWER;
   assign link.notify_type  = NOTIFY_TYPE;
   assign link.is_in        = IS_IN;
   // Answer lines come straight from registers
   assign link.hs           = st.hs;
   assign link.ddata        = st.ddata;
   assign link.dseq         = st.dseq;
   assign link.ready_notice = st.ready_notice;
   assign halted            = st.halted;
   // Protocol: answers in the cycle after the token
   always_comb begin
      next_st = st;
      next_st.hs = wie_pkg::WIE_HS_NONE;
      next_st.ready_notice = 1'b0;
      // Liveness timer in 128 us units, only low-power IN uses it
      if (st.unit_cnt >= 32'(UNIT_CYCLES - 1)) begin
         next_st.unit_cnt = '0;
         if (st.live_cnt != 16'h0000) next_st.live_cnt = st.live_cnt - 1'b1;
      end else begin
         next_st.unit_cnt = st.unit_cnt + 1'b1;
      end
      // Halt request applies first and last so set wins
      if (halt_req) next_st.halted = 1'b1;
      // At most one answer per token; a halted pipe stalls data polls
      if (in_tok) begin
         if (st.halted) begin
            next_st.hs = wie_pkg::WIE_HS_STALL;
         end else if (f_out_valid) begin
            // Poll at any time is served; no spacing assumed
            next_st.hs = wie_pkg::WIE_HS_DATA;
            next_st.ddata = f_out_data;
            next_st.dseq = st.tx_seq;
            next_st.pend_data = 1'b1;
         end else if (!LOW_POWER) begin
            next_st.hs = wie_pkg::WIE_HS_NAK;
            next_st.flow_ctl = 1'b1;
         end else if (st.live_cnt == 16'h0000) begin
            // Low-power stays silent until the timer runs out
            next_st.hs = wie_pkg::WIE_HS_NAK;
            next_st.live_cnt = LIVE_UNITS;
            next_st.flow_ctl = 1'b1;
         end
      end else if (out_tok && IS_IN) begin
         // Host ACK of last DATA toggles the window
         if (in_ack) begin
            next_st.tx_seq = ~st.tx_seq;
            next_st.pend_data = 1'b0;
         end
      end else if (out_tok) begin
         if (st.halted) begin
            next_st.hs = wie_pkg::WIE_HS_STALL;
         end else if (!f_in_ready) begin
            next_st.hs = wie_pkg::WIE_HS_NAK;
            next_st.flow_ctl = 1'b1;
         end else begin
            next_st.hs = wie_pkg::WIE_HS_ACK;
            if (out_fresh) next_st.rx_seq = ~st.rx_seq;
         end
      end else if (ctrl_tok) begin
         // Set-feature halts; the others rewind
         if (link.req == wie_pkg::REQ_SET_FEAT) begin
            next_st.halted = 1'b1;
         end
         // Halt clears together with the window
         if (rewind) begin
            next_st.tx_seq = 1'b0;
            next_st.rx_seq = 1'b0;
            next_st.pend_data = 1'b0;
            next_st.halted = 1'b0;
         end
         next_st.hs = wie_pkg::WIE_HS_ACK;
      end
      // No endpoint announces readiness: flow_ctl is tested before it clears, so notifying ones stay silent too
      if (NOTIFY_TYPE && st.flow_ctl && !next_st.flow_ctl) begin
         next_st.ready_notice = 1'b1;
      end
      if (st.flow_ctl && (IS_IN ? f_out_valid : f_in_ready)
          && !in_tok && !out_tok) begin
         next_st.flow_ctl = 1'b0;
      end
      if (halt_req) next_st.halted = 1'b1;
   end
   // Synchronous reset clears the record; hs resets to NONE
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st <= '0;
         st.hs <= wie_pkg::WIE_HS_NONE;
      end else begin
         st <= next_st;
      end
   end
   // data_ready kept for user-side flow hints
   // Nothing reads it yet; port kept for a later policy
   logic unused_hint;
   assign unused_hint = data_ready;
endmodule
`default_nettype wire

/* hdl/wie_host.sv */
`timescale 1ns/1ps
`default_nettype none
module wie_host #(
   parameter int         WIDTH       = 8,
   parameter logic [4:0] GRANT_EXP   = 5'h00,
   parameter int         UNIT_CYCLES = wie_pkg::UNIT_CYCLES
) (
   input  wire logic             ref_clk,
   input  wire logic             rst,
   wie_link_if.host              link,
   input  wire logic             ctrl_go,
   input  wire logic [1:0]       ctrl_req,
   input  wire logic             out_valid,
   input  wire logic [WIDTH-1:0] out_data,
   output logic                  out_ready,
   output logic                  in_valid,
   output logic      [WIDTH-1:0] in_data,
   output logic                  pipe_halted,
   output logic                  interval_tick
);
   initial begin
      if (UNIT_CYCLES < 1) $error("UNIT_CYCLES must be positive");
   end
   typedef enum logic [3:0] {
      WIE_H_IDLE = 4'b0001, WIE_H_WAIT = 4'b0010,
      WIE_H_DONE = 4'b0100, WIE_H_HOLD = 4'b1000
   } wie_hst_e;
   typedef struct packed {
      wie_hst_e          state;
      wie_pkg::wie_tok_e tok;
      logic [1:0]        req;
      logic              seq;
      logic              exp_seq;
      logic [WIDTH-1:0]  hdata;
      logic              in_valid;
      logic [WIDTH-1:0]  in_data;
      logic              halted;
      logic              tick;
      logic [2:0]        tries;
      logic [31:0]       unit_cnt;
      logic [15:0]       ivl_cnt;
   } wie_host_s;
   wie_host_s st, next_st;
   logic [4:0]  eff_exp;
   logic [15:0] ivl_units;
   // Host may grant a shorter interval than asked
   assign eff_exp   = (GRANT_EXP != 5'h00 && GRANT_EXP < link.exponent)
                      ? GRANT_EXP : link.exponent;
   assign ivl_units = 16'((17'h1 << (eff_exp - 5'h01)) - 17'h1);
   assign link.tok  = st.tok;
   assign link.req  = st.req;
   assign link.seq  = st.seq;
   assign link.hdata = st.hdata;
   assign in_valid  = st.in_valid;
   assign in_data   = st.in_data;
   assign pipe_halted = st.halted;
   assign interval_tick = st.tick;
   assign out_ready = st.state == WIE_H_WAIT && !link.is_in
                      && link.hs == wie_pkg::WIE_HS_ACK;
   // One poll at the start of each interval; retries follow
   always_comb begin
      next_st = st;
      next_st.tok = wie_pkg::WIE_TOK_NONE;
      next_st.in_valid = 1'b0;
      next_st.tick = 1'b0;
      if (st.unit_cnt >= 32'(UNIT_CYCLES - 1)) begin
         next_st.unit_cnt = '0;
         if (st.ivl_cnt >= ivl_units) begin
            next_st.ivl_cnt = '0;
            next_st.tick = 1'b1;
         end else begin
            next_st.ivl_cnt = st.ivl_cnt + 1'b1;
         end
      end else begin
         next_st.unit_cnt = st.unit_cnt + 1'b1;
      end
      if (ctrl_go && st.state != WIE_H_WAIT) begin
         next_st.tok = wie_pkg::WIE_TOK_CTRL;
         next_st.req = ctrl_req;
         next_st.state = WIE_H_WAIT;
      end else begin
         case (st.state)
         WIE_H_IDLE: begin
            // Single periodic slot keeps use well under 80 percent
            if (st.tick && !st.halted && (link.is_in || out_valid)) begin
               next_st.tok = link.is_in ? wie_pkg::WIE_TOK_IN
                                        : wie_pkg::WIE_TOK_OUT;
               next_st.seq = st.exp_seq;
               next_st.hdata = out_data;
               next_st.tries = 3'h1;
               next_st.state = WIE_H_WAIT;
            end
         end
         WIE_H_WAIT: begin
            if (st.req != wie_pkg::REQ_SET_FEAT && link.hs ==
                wie_pkg::WIE_HS_ACK && st.tok == wie_pkg::WIE_TOK_NONE
                && ctrl_go) begin
               next_st.state = WIE_H_WAIT;
            end
            case (link.hs)
            wie_pkg::WIE_HS_DATA: begin
               if (link.dseq == st.exp_seq) begin
                  next_st.in_valid = 1'b1;
                  next_st.in_data = link.ddata;
                  next_st.exp_seq = ~st.exp_seq;
               end
               next_st.tok = wie_pkg::WIE_TOK_OUT; // Handshake ACK
               next_st.state = WIE_H_DONE;
            end
            wie_pkg::WIE_HS_ACK: begin
               if (st.req != wie_pkg::REQ_SET_FEAT && st.tries == 3'h0) begin
                  // Rewind only once control has completed
                  next_st.exp_seq = 1'b0;
                  next_st.halted = 1'b0;
               end else if (!link.is_in) begin
                  next_st.exp_seq = ~st.exp_seq;
               end
               next_st.tries = 3'h0;
               next_st.state = WIE_H_DONE;
            end
            wie_pkg::WIE_HS_NAK: begin
               // Flow control: wait next interval or a ready notice
               next_st.state = link.notify_type ? WIE_H_HOLD
                                                : WIE_H_DONE;
            end
            wie_pkg::WIE_HS_STALL: begin
               next_st.halted = 1'b1;
               next_st.state = WIE_H_IDLE;
            end
            default: begin
               // Silence counts as a failed attempt
               if (st.tok == wie_pkg::WIE_TOK_NONE) begin
                  if (st.tries >= (link.low_power ? 3'(wie_pkg::LP_ATTEMPTS)
                                   : wie_pkg::RETRY_LIMIT)) begin
                     // Low-power: silence means postpone, not halt
                     next_st.halted = !link.low_power;
                     next_st.state = WIE_H_DONE;
                  end else if (st.tries != 3'h0 && !link.low_power) begin
                     next_st.tok = link.is_in ? wie_pkg::WIE_TOK_IN
                                              : wie_pkg::WIE_TOK_OUT;
                     next_st.tries = st.tries + 1'b1;
                  end else if (st.tries != 3'h0) begin
                     next_st.state = WIE_H_DONE;
                  end
               end
            end
            endcase
         end
         WIE_H_DONE: begin
            next_st.state = WIE_H_IDLE;
         end
         WIE_H_HOLD: begin
            if (link.ready_notice) next_st.state = WIE_H_IDLE;
         end
         default: next_st.state = WIE_H_IDLE;
         endcase
      end
      if (ctrl_go) next_st.tries = 3'h0;
   end
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st <= '0;
         st.state <= WIE_H_IDLE;
         st.tok <= wie_pkg::WIE_TOK_NONE;
      end else begin
         st <= next_st;
      end
   end
endmodule
`default_nettype wire

/* tb/wie_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module wie_properties #(
   parameter int WIDTH = 8
) (
   input wire logic              ref_clk,
   input wire logic              rst,
   input wire wie_pkg::wie_tok_e tok,
   input wire logic [1:0]        req,
   input wire logic              seq,
   input wire logic [WIDTH-1:0]  hdata,
   input wire logic [4:0]        exponent,
   input wire logic              low_power,
   input wire logic              notify_type,
   input wire logic              is_in,
   input wire wie_pkg::wie_hs_e  hs,
   input wire logic [WIDTH-1:0]  ddata,
   input wire logic              dseq,
   input wire logic              ready_notice
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   logic dev_stop;
   logic host_stop;
   // Shadow halt views; set-feature halts the device, STALL halts the host
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         dev_stop  <= 1'b0;
         host_stop <= 1'b0;
      end else if (tok == wie_pkg::WIE_TOK_CTRL) begin
         // Every request but set-feature rewinds and lifts the halt
         if (req != wie_pkg::REQ_SET_FEAT) begin
            dev_stop  <= 1'b0;
            host_stop <= 1'b0;
         end else begin
            dev_stop <= 1'b1;
         end
      end else if (hs == wie_pkg::WIE_HS_STALL) begin
         host_stop <= 1'b1;
      end
   end

   AST_EXP_RANGE: assert property (exponent >= wie_pkg::EXP_MIN &&
      exponent <= wie_pkg::EXP_MAX) else $error("exponent out of range");
   AST_EXP_STATIC: assert property ($stable(exponent) && $stable(is_in))
      else $error("interval exponent moved");
   AST_IN_ANSWER: assert property (tok == wie_pkg::WIE_TOK_IN && !low_power
      |=> hs inside {wie_pkg::WIE_HS_DATA, wie_pkg::WIE_HS_NAK,
      wie_pkg::WIE_HS_STALL}) else $error("poll left unanswered");
   AST_ANSWER_CAUSE: assert property (hs != wie_pkg::WIE_HS_NONE
      |-> $past(tok) != wie_pkg::WIE_TOK_NONE) else $error("answer unasked");
   AST_NO_NOTICE: assert property (!notify_type |-> !ready_notice)
      else $error("ready notice from periodic endpoint");
   AST_HALT_STALL: assert property (tok == wie_pkg::WIE_TOK_IN && dev_stop
      |=> hs == wie_pkg::WIE_HS_STALL) else $error("halted poll not stalled");
   AST_HOST_HALT: assert property (host_stop |-> tok != wie_pkg::WIE_TOK_IN)
      else $error("host polls a halted pipe");
   AST_NAK_RESUME: assert property (hs == wie_pkg::WIE_HS_NAK
      |=> (tok != wie_pkg::WIE_TOK_IN)[*8]) else $error("poll after NAK");
   AST_DATA_ACK: assert property (hs == wie_pkg::WIE_HS_DATA
      |=> tok == wie_pkg::WIE_TOK_OUT) else $error("data not acknowledged");

   cover property (hs == wie_pkg::WIE_HS_DATA);
   cover property (hs == wie_pkg::WIE_HS_NAK);
   cover property (hs == wie_pkg::WIE_HS_STALL);
   cover property (tok == wie_pkg::WIE_TOK_CTRL);
endmodule
`default_nettype wire

/* tb/wie_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module wie_tb_top;
   localparam int UNIT   = 4;
   localparam int PERIOD = (1 << (int'(wie_pkg::EXP_DEFAULT) - 1)) * UNIT;

   logic       ref_clk, rst, user_valid, user_ready, halt_req, halted;
   logic       ctrl_go, in_valid, pipe_halted, interval_tick;
   logic [1:0] ctrl_req;
   logic [7:0] user_data, in_data;
   logic [7:0] model_q[$];
   int         bad_count, checks, nak_seen, n, i, seed;
   bit         took, refused;

   wie_link_if #(.WIDTH(8)) wie_link_if_inst ();
   // Short time unit keeps one interval at 128 cycles
   wie_device #(.UNIT_CYCLES(UNIT), .LIVE_UNITS(16'h0004)) wie_device_inst (
      .ref_clk(ref_clk), .rst(rst), .link(wie_link_if_inst),
      .user_valid(user_valid), .user_ready(user_ready),
      .user_data(user_data), .recv_valid(), .recv_ready(1'b1),
      .recv_data(), .halt_req(halt_req), .halted(halted),
      .data_ready(user_valid));
   wie_host #(.UNIT_CYCLES(UNIT)) wie_host_inst (
      .ref_clk(ref_clk), .rst(rst), .link(wie_link_if_inst),
      .ctrl_go(ctrl_go), .ctrl_req(ctrl_req), .out_valid(1'b0),
      .out_data(user_data), .out_ready(), .in_valid(in_valid),
      .in_data(in_data), .pipe_halted(pipe_halted),
      .interval_tick(interval_tick));
   wie_properties wie_properties_inst (
      .ref_clk(ref_clk), .rst(rst), .tok(wie_link_if_inst.tok),
      .req(wie_link_if_inst.req), .seq(wie_link_if_inst.seq),
      .hdata(wie_link_if_inst.hdata),
      .exponent(wie_link_if_inst.exponent),
      .low_power(wie_link_if_inst.low_power),
      .notify_type(wie_link_if_inst.notify_type),
      .is_in(wie_link_if_inst.is_in), .hs(wie_link_if_inst.hs),
      .ddata(wie_link_if_inst.ddata), .dseq(wie_link_if_inst.dseq),
      .ready_notice(wie_link_if_inst.ready_notice));

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic report(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic check_word(input logic [7:0] got, input logic [7:0] exp);
      report({24'h000000, got}, {24'h000000, exp});
   endtask
   task automatic check_bit(input logic got, input logic exp);
      report({31'h00000000, got}, {31'h00000000, exp});
   endtask
   task automatic check_count(input int got, input int exp);
      report(got, exp);
   endtask

   task complete_run;
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // A wait that uses up its bound ends the run as a failure
   task give_up;
      bad_count++;
      complete_run;
   endtask

   // Ready is combinational, so it is read at the falling edge
   task automatic push(input logic [7:0] w, output bit ok);
      ok = 1'b0;
      user_valid = 1'b1;
      user_data = w;
      for (int k = 0; k < 4 && !ok; k++) begin
         @(negedge ref_clk);
         ok = (user_ready === 1'b1);
         @(posedge ref_clk);
         #1;
      end
      if (ok) model_q.push_back(w);
      user_valid = 1'b0;
      @(posedge ref_clk);
      #1;
   endtask
   // Held until the host takes it; a poll in flight defers it
   task automatic ctrl(input logic [1:0] code);
      bit seen;
      seen = 1'b0;
      ctrl_go = 1'b1;
      ctrl_req = code;
      for (int k = 0; k < 8 && !seen; k++) begin
         @(posedge ref_clk);
         #1;
         seen = (wie_link_if_inst.tok === wie_pkg::WIE_TOK_CTRL);
      end
      ctrl_go = 1'b0;
      if (!seen) give_up;
      repeat (4) @(posedge ref_clk);
      #1;
   endtask
   task automatic wait_tick(output int c);
      for (c = 1; c < 1000 && interval_tick !== 1'b1; c++) begin
         @(posedge ref_clk);
         #1;
      end
      if (c >= 1000) give_up;
   endtask
   task automatic wait_halt(input logic want);
      for (int k = 0; k < 800 && pipe_halted !== want; k++) begin
         @(posedge ref_clk);
         #1;
      end
      if (pipe_halted !== want) give_up;
   endtask
   task automatic drain;
      for (int k = 0; k < 6000 && model_q.size() != 0; k++)
         @(posedge ref_clk);
      #1;
      check_count(model_q.size(), 0);
      if (model_q.size() != 0) give_up;
   endtask

   // Delivered words against the model; read off the launch edge
   always @(negedge ref_clk) begin
      if (!rst && in_valid === 1'b1) begin
         if (model_q.size() == 0) check_count(0, 1);
         else check_word(in_data, model_q.pop_front());
      end
      if (wie_link_if_inst.hs === wie_pkg::WIE_HS_NAK) nak_seen++;
   end

   // Watchdog against a hung handshake
   initial begin
      repeat (90000) @(posedge ref_clk);
      bad_count++;
      complete_run;
   end

   initial begin
      seed = 32'hC1C2C928;
      rst = 1'b1;
      {user_valid, halt_req, ctrl_go} = 3'h0;
      user_data = 8'h00;
      ctrl_req = 2'h0;
      repeat (20) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      // Interval spacing while the endpoint sits empty
      wait_tick(n);
      @(posedge ref_clk);
      #1;
      wait_tick(n);
      check_count(n, PERIOD);
      wait_tick(n);
      check_bit(nak_seen != 0, 1'b1);
      // Fill past capacity while the host drains slowly
      refused = 1'b0;
      for (i = 0; i < 24; i++) begin
         push(8'($random(seed)), took);
         if (!took) refused = 1'b1;
      end
      check_bit(refused, 1'b1);
      drain;
      // Local halt stalls the next poll, clear-feature recovers
      halt_req = 1'b1;
      @(posedge ref_clk);
      #1;
      halt_req = 1'b0;
      check_bit(halted, 1'b1);
      wait_halt(1'b1);
      check_bit(pipe_halted, 1'b1);
      ctrl(wie_pkg::REQ_CLEAR_FEAT);
      check_bit(halted, 1'b0);
      wait_halt(1'b0);
      check_bit(pipe_halted, 1'b0);
      // Every control code, traffic after each rewind
      for (i = 0; i < 4; i++) begin
         ctrl(i[1:0]);
         check_bit(halted, i == 3);
         if (i == 3) begin
            wait_halt(1'b1);
            check_bit(pipe_halted, 1'b1);
            ctrl(wie_pkg::REQ_CLEAR_FEAT);
         end
         push(8'($random(seed)), took);
         push(8'($random(seed)), took);
         drain;
      end
      complete_run;
   end
endmodule
`default_nettype wire
